// [core/delay_counter.sv]
// restartable up-counter that pulses done at a terminal count
`timescale 1ns/1ns
`default_nettype none

module delay_counter (
    input wire logic i_clk,
    input wire logic i_reset_n,
    input wire logic i_start,
    input wire logic i_tick,
    input wire logic [15:0] i_limit,
    output logic o_busy,
    output logic o_done
);

    wakeup_lvr_pkg::delay_state_t s_q;
    wakeup_lvr_pkg::delay_state_t s_d;

    always_comb begin
        s_d = s_q;
        s_d.done = 1'b0;
        if (i_start) begin
            s_d.busy = 1'b1;
            s_d.cnt = 16'h0000;
        end else if (s_q.busy && i_tick) begin
            s_d.cnt = s_q.cnt + 16'h0001;
            // a limit of zero ends on the first tick rather than wrapping
            if (s_d.cnt >= i_limit) begin
                s_d.busy = 1'b0;
                s_d.done = 1'b1;
            end
        end
    end

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign o_busy = s_q.busy;
    assign o_done = s_q.done;

endmodule : delay_counter

`default_nettype wire

// [core/wakeup_lvr_ctrl.sv]
// option register with wake-up, low-voltage reset and watchdog sequencing
`timescale 1ns/1ns
`default_nettype none

`include "wakeup_lvr_params.svh"

// Operation
// - bit 6 lowers crystal drive once running
// - normal wake waits 1024 low RC ticks
// - fast wake is 128 cycles plus stabilisation
// - exec-stop fast wake adds no stabilisation
// - system-stop fast wake adds RC startup time
// - fast wake clocks watchdog from system clock
// - bit 4 enables half-supply bias on pins
// - bit 3 clear: 1024 tick boot delay
// - bit 3 set: 64 tick boot delay
// - bit 2 set disables low-voltage reset
// - bits 1:0 select watchdog timeout period
module wakeup_lvr_ctrl (
    input wire logic I_CLK,
    input wire logic I_RESET_N,
    input wire logic I_WB_CYC,
    input wire logic I_WB_STB,
    input wire logic I_WB_WE,
    input wire logic [7:0] I_WB_ADR,
    input wire logic [3:0] I_WB_SEL,
    input wire logic [31:0] I_WB_DAT,
    input wire logic I_LRC_TICK,
    input wire logic I_WAKE_REQ,
    input wire logic I_SUSPEND_SYS,
    input wire logic I_HIGH_RC_USED,
    input wire logic I_EXT_OSC_EN,
    input wire logic I_XTAL_RUNNING,
    input wire logic I_LVR_LOW,
    input wire logic I_WDT_ENABLE,
    input wire logic I_WDT_KICK,
    output logic O_WB_ACK,
    output logic [31:0] O_WB_DAT,
    output logic O_XTAL_LOW_DRIVE,
    output logic [3:0] O_HALF_VDD_EN,
    output logic O_WAKE_HOLD,
    output logic O_WAKE_DONE,
    output logic O_LVR_RESET,
    output logic O_BOOT_HOLD,
    output logic O_WDT_TIMEOUT,
    output logic O_WDT_SYS_CLK
);

    // ------------------------------------------------------------------
    // derived timing
    // ------------------------------------------------------------------
    localparam int HIGH_RC_STABLE_CYC = `HIGH_RC_STABLE_US * `SYS_CLK_MHZ;
    localparam int LOW_RC_STABLE_CYC = `LOW_RC_STABLE_US * `SYS_CLK_MHZ;
    localparam logic [15:0] HIGH_RC_LIMIT = HIGH_RC_STABLE_CYC[15:0];
    localparam logic [15:0] LOW_RC_LIMIT = LOW_RC_STABLE_CYC[15:0];

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    wakeup_lvr_pkg::core_state_t s_q;
    wakeup_lvr_pkg::core_state_t s_d;

    logic wake_busy;
    logic wake_cnt_done;
    logic wake_tick;
    logic [15:0] wake_limit;
    logic boot_busy;
    logic boot_cnt_done;
    logic [15:0] boot_limit;
    logic wdt_timeout;
    logic wdt_sys;
    logic bus_req;
    logic opt_hit;
    logic stat_hit;
    logic fast_wake;
    logic lvr_off;
    logic misuse;
    logic [7:0] status;

    assign fast_wake = s_q.opt[`OPT_FAST_WAKE_BIT];
    assign lvr_off = s_q.opt[`OPT_LVR_DIS_BIT];
    // only flagged: the unsupported mix is the software's to avoid
    assign misuse = fast_wake & I_EXT_OSC_EN;

    // ------------------------------------------------------------------
    // bus decode
    // ------------------------------------------------------------------
    assign bus_req = I_WB_CYC & I_WB_STB & ~s_q.ack;
    assign opt_hit = (I_WB_ADR[7:2] == `OPT_REG_INDEX);
    assign stat_hit = (I_WB_ADR[7:2] == `STAT_REG_INDEX);

    always_comb begin
        status = 8'h00;
        status[`STAT_WAKE_HOLD_BIT] = (s_q.wake != wakeup_lvr_pkg::WAKE_IDLE);
        status[`STAT_BOOT_HOLD_BIT] = (s_q.lvr != wakeup_lvr_pkg::LVR_RUN);
        status[`STAT_LVR_RESET_BIT] = (s_q.lvr == wakeup_lvr_pkg::LVR_HOLD);
        status[`STAT_WDT_SYS_BIT] = wdt_sys;
        status[`STAT_MISUSE_BIT] = misuse;
    end

    // ------------------------------------------------------------------
    // delay limits and tick selection
    // ------------------------------------------------------------------
    always_comb begin
        wake_tick = 1'b1;
        case (s_q.wake)
            wakeup_lvr_pkg::WAKE_SLOW: begin
                wake_tick = I_LRC_TICK;
                wake_limit = `SLOW_WAKE_TICKS;
            end
            wakeup_lvr_pkg::WAKE_FAST: begin
                wake_limit = `FAST_WAKE_CYC;
            end
            wakeup_lvr_pkg::WAKE_STABLE: begin
                // startup time of whichever RC oscillator feeds the core
                wake_limit = s_q.wake_hrc ? HIGH_RC_LIMIT : LOW_RC_LIMIT;
            end
            default: begin
                wake_limit = `FAST_WAKE_CYC;
            end
        endcase
    end

    assign boot_limit = s_q.lvr_fast ? `LVR_BOOT_FAST : `LVR_BOOT_SLOW;

    // ------------------------------------------------------------------
    // next state
    // ------------------------------------------------------------------
    always_comb begin
        s_d = s_q;
        s_d.ack = 1'b0;
        s_d.wake_start = 1'b0;
        s_d.wake_done = 1'b0;
        s_d.lvr_start = 1'b0;

        // register access; the option register is write-only
        if (bus_req) begin
            s_d.ack = 1'b1;
            s_d.rdata = 8'h00;
            if (!I_WB_WE && stat_hit) begin
                s_d.rdata = status;
            end
        end
        // a write lands on the acked edge, while the request still stands
        if (s_q.ack && I_WB_CYC && I_WB_STB && I_WB_WE) begin
            if (opt_hit && I_WB_SEL[0]) begin
                s_d.opt = I_WB_DAT[7:0] & `OPT_WRITE_MASK;
            end
        end

        // pin controls follow the option bits
        s_d.xtal_low = s_q.opt[`OPT_XTAL_LOW_BIT] & I_XTAL_RUNNING;
        s_d.half_vdd = {4{s_q.opt[`OPT_HALF_VDD_BIT]}};

        // wake-up sequencer
        case (s_q.wake)
            wakeup_lvr_pkg::WAKE_IDLE: begin
                if (I_WAKE_REQ) begin
                    s_d.wake_sys = I_SUSPEND_SYS;
                    s_d.wake_hrc = I_HIGH_RC_USED;
                    s_d.wake_start = 1'b1;
                    if (fast_wake) begin
                        s_d.wake = wakeup_lvr_pkg::WAKE_FAST;
                    end else begin
                        s_d.wake = wakeup_lvr_pkg::WAKE_SLOW;
                    end
                end
            end
            wakeup_lvr_pkg::WAKE_SLOW: begin
                if (wake_cnt_done) begin
                    s_d.wake = wakeup_lvr_pkg::WAKE_DONE;
                end
            end
            wakeup_lvr_pkg::WAKE_FAST: begin
                if (wake_cnt_done) begin
                    if (s_q.wake_sys) begin
                        s_d.wake_start = 1'b1;
                        s_d.wake = wakeup_lvr_pkg::WAKE_STABLE;
                    end else begin
                        // oscillator never stopped, nothing to wait for
                        s_d.wake = wakeup_lvr_pkg::WAKE_DONE;
                    end
                end
            end
            wakeup_lvr_pkg::WAKE_STABLE: begin
                if (wake_cnt_done) begin
                    s_d.wake = wakeup_lvr_pkg::WAKE_DONE;
                end
            end
            wakeup_lvr_pkg::WAKE_DONE: begin
                s_d.wake_done = 1'b1;
                s_d.wake = wakeup_lvr_pkg::WAKE_IDLE;
            end
            default: begin
                s_d.wake = wakeup_lvr_pkg::WAKE_IDLE;
            end
        endcase

        // low-voltage reset sequencer
        case (s_q.lvr)
            wakeup_lvr_pkg::LVR_RUN: begin
                if (I_LVR_LOW && !lvr_off) begin
                    s_d.lvr = wakeup_lvr_pkg::LVR_HOLD;
                end
            end
            wakeup_lvr_pkg::LVR_HOLD: begin
                if (lvr_off) begin
                    s_d.lvr = wakeup_lvr_pkg::LVR_RUN;
                end else if (!I_LVR_LOW) begin
                    s_d.lvr_fast = s_q.opt[`OPT_LVR_FAST_BIT];
                    s_d.lvr_start = 1'b1;
                    s_d.lvr = wakeup_lvr_pkg::LVR_BOOT;
                end
            end
            wakeup_lvr_pkg::LVR_BOOT: begin
                // a new dip restarts the whole recovery
                if (I_LVR_LOW && !lvr_off) begin
                    s_d.lvr = wakeup_lvr_pkg::LVR_HOLD;
                end else if (boot_cnt_done) begin
                    s_d.lvr = wakeup_lvr_pkg::LVR_RUN;
                end
            end
            default: begin
                s_d.lvr = wakeup_lvr_pkg::LVR_RUN;
            end
        endcase
    end

    always_ff @(posedge I_CLK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            s_q <= '0;
            s_q.opt <= `OPT_RESET;
        end else begin
            s_q <= s_d;
        end
    end

    // ------------------------------------------------------------------
    // counters
    // ------------------------------------------------------------------
    delay_counter u_wake_cnt (
        .i_clk(I_CLK),
        .i_reset_n(I_RESET_N),
        .i_start(s_q.wake_start),
        .i_tick(wake_tick),
        .i_limit(wake_limit),
        .o_busy(wake_busy),
        .o_done(wake_cnt_done)
    );

    delay_counter u_boot_cnt (
        .i_clk(I_CLK),
        .i_reset_n(I_RESET_N),
        .i_start(s_q.lvr_start),
        .i_tick(I_LRC_TICK),
        .i_limit(boot_limit),
        .o_busy(boot_busy),
        .o_done(boot_cnt_done)
    );

    // software is expected to stop the dog across a fast wake
    watchdog_timer u_wdt (
        .i_clk(I_CLK),
        .i_reset_n(I_RESET_N),
        .i_enable(I_WDT_ENABLE),
        .i_kick(I_WDT_KICK),
        .i_sys_src(fast_wake),
        .i_lrc_tick(I_LRC_TICK),
        .i_period_sel(s_q.opt[`OPT_WDT_SEL_HI:`OPT_WDT_SEL_LO]),
        .o_timeout(wdt_timeout),
        .o_sys_src(wdt_sys)
    );

    // ------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------
    assign O_WB_ACK = s_q.ack;
    assign O_WB_DAT = {24'h000000, s_q.rdata};
    assign O_XTAL_LOW_DRIVE = s_q.xtal_low;
    assign O_HALF_VDD_EN = s_q.half_vdd;
    assign O_WAKE_HOLD = (s_q.wake != wakeup_lvr_pkg::WAKE_IDLE) | wake_busy;
    assign O_WAKE_DONE = s_q.wake_done;
    assign O_LVR_RESET = (s_q.lvr == wakeup_lvr_pkg::LVR_HOLD);
    assign O_BOOT_HOLD = (s_q.lvr != wakeup_lvr_pkg::LVR_RUN) | boot_busy;
    assign O_WDT_TIMEOUT = wdt_timeout;
    assign O_WDT_SYS_CLK = wdt_sys;

endmodule : wakeup_lvr_ctrl

`default_nettype wire

// [core/wakeup_lvr_params.svh]
// constants for the wake-up, low-voltage reset and watchdog option block
`ifndef WAKEUP_LVR_PARAMS_SVH
`define WAKEUP_LVR_PARAMS_SVH

// ----------------------------------------------------------------------
// register map (word index, byte address is four times the index)
// ----------------------------------------------------------------------
`define OPT_REG_INDEX 6'h3b
`define STAT_REG_INDEX 6'h3f
`define OPT_RESET 8'h00

// ----------------------------------------------------------------------
// option register fields
// ----------------------------------------------------------------------
`define OPT_XTAL_LOW_BIT 6
`define OPT_FAST_WAKE_BIT 5
`define OPT_HALF_VDD_BIT 4
`define OPT_LVR_FAST_BIT 3
`define OPT_LVR_DIS_BIT 2
`define OPT_WDT_SEL_HI 1
`define OPT_WDT_SEL_LO 0
`define OPT_WRITE_MASK 8'h7f

// ----------------------------------------------------------------------
// status register fields
// ----------------------------------------------------------------------
`define STAT_WAKE_HOLD_BIT 0
`define STAT_BOOT_HOLD_BIT 1
`define STAT_LVR_RESET_BIT 2
`define STAT_WDT_SYS_BIT 3
`define STAT_MISUSE_BIT 4

// ----------------------------------------------------------------------
// delay counts
// ----------------------------------------------------------------------
`define SLOW_WAKE_TICKS 16'h0400
`define FAST_WAKE_CYC 16'h0080
`define LVR_BOOT_SLOW 16'h0400
`define LVR_BOOT_FAST 16'h0040
`define WDT_PERIOD_00 16'h0800
`define WDT_PERIOD_01 16'h1000
`define WDT_PERIOD_10 16'h4000
`define WDT_PERIOD_11 16'h0100
`define SYS_CLK_MHZ 25
`define HIGH_RC_STABLE_US 20
`define LOW_RC_STABLE_US 100

`endif

// [core/wakeup_lvr_pkg.sv]
// types shared by the wake-up, low-voltage reset and watchdog block
package wakeup_lvr_pkg;

    typedef enum logic [2:0] {
        WAKE_IDLE = 3'h0,
        WAKE_SLOW = 3'h1,
        WAKE_FAST = 3'h2,
        WAKE_STABLE = 3'h3,
        WAKE_DONE = 3'h4
    } wake_state_t;

    typedef enum logic [1:0] {
        LVR_RUN = 2'h0,
        LVR_HOLD = 2'h1,
        LVR_BOOT = 2'h2
    } lvr_state_t;

    typedef struct packed {
        logic busy;
        logic done;
        logic [15:0] cnt;
    } delay_state_t;

    typedef struct packed {
        logic [15:0] cnt;
        logic timeout;
        logic src_sys;
    } wdt_state_t;

    typedef struct packed {
        logic [7:0] opt;
        wake_state_t wake;
        logic wake_sys;
        logic wake_hrc;
        logic wake_start;
        logic wake_done;
        lvr_state_t lvr;
        logic lvr_fast;
        logic lvr_start;
        logic xtal_low;
        logic [3:0] half_vdd;
        logic ack;
        logic [7:0] rdata;
    } core_state_t;

endpackage : wakeup_lvr_pkg

// [core/watchdog_timer.sv]
// watchdog counter with selectable period and clock source
`timescale 1ns/1ns
`default_nettype none

`include "wakeup_lvr_params.svh"

module watchdog_timer (
    input wire logic i_clk,
    input wire logic i_reset_n,
    input wire logic i_enable,
    input wire logic i_kick,
    input wire logic i_sys_src,
    input wire logic i_lrc_tick,
    input wire logic [1:0] i_period_sel,
    output logic o_timeout,
    output logic o_sys_src
);

    wakeup_lvr_pkg::wdt_state_t s_q;
    wakeup_lvr_pkg::wdt_state_t s_d;
    logic [15:0] limit;
    logic tick;

    always_comb begin
        case (i_period_sel)
            2'b00: limit = `WDT_PERIOD_00;
            2'b01: limit = `WDT_PERIOD_01;
            2'b10: limit = `WDT_PERIOD_10;
            2'b11: limit = `WDT_PERIOD_11;
            default: limit = `WDT_PERIOD_00;
        endcase
    end

    // fast system clock shortens the period greatly while selected
    assign tick = i_sys_src ? 1'b1 : i_lrc_tick;

    always_comb begin
        s_d = s_q;
        s_d.timeout = 1'b0;
        s_d.src_sys = i_sys_src;
        // a source change restarts the count so units are never mixed
        if (!i_enable || i_kick || (i_sys_src != s_q.src_sys)) begin
            s_d.cnt = 16'h0000;
        end else if (tick) begin
            s_d.cnt = s_q.cnt + 16'h0001;
            if (s_d.cnt >= limit) begin
                s_d.cnt = 16'h0000;
                s_d.timeout = 1'b1;
            end
        end
    end

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign o_timeout = s_q.timeout;
    assign o_sys_src = s_q.src_sys;

endmodule : watchdog_timer

`default_nettype wire

// [sim/wakeup_lvr_ctrl_monitor.sv]
// assertion checker for the option register and sequencing block
`timescale 1ns/1ns
`default_nettype none

module wakeup_lvr_ctrl_monitor (
    input wire logic I_CLK,
    input wire logic I_RESET_N,
    input wire logic I_WB_CYC,
    input wire logic I_WB_STB,
    input wire logic I_XTAL_RUNNING,
    input wire logic I_WAKE_REQ,
    input wire logic I_LVR_LOW,
    input wire logic I_WDT_ENABLE,
    input wire logic O_WB_ACK,
    input wire logic [31:0] O_WB_DAT,
    input wire logic O_XTAL_LOW_DRIVE,
    input wire logic [3:0] O_HALF_VDD_EN,
    input wire logic O_WAKE_HOLD,
    input wire logic O_WAKE_DONE,
    input wire logic O_LVR_RESET,
    input wire logic O_BOOT_HOLD,
    input wire logic O_WDT_TIMEOUT
);
    default clocking cb @(posedge I_CLK);
    endclocking
    default disable iff (!I_RESET_N);

    // ------
    // bus answer
    // ------
    a_ack_follows_req: assert property (I_WB_CYC && I_WB_STB && !O_WB_ACK
        |=> O_WB_ACK) else $error("ack missing one cycle after request");
    a_ack_one_cycle: assert property (O_WB_ACK |=> !O_WB_ACK)
        else $error("ack held longer than one cycle");
    a_dat_upper_zero: assert property (O_WB_DAT[31:8] == 24'h000000)
        else $error("read data upper bytes not zero");

    // ------
    // option outputs and sequencers
    // ------
    a_xtal_needs_run: assert property (
        O_XTAL_LOW_DRIVE |-> $past(I_XTAL_RUNNING))
        else $error("low drive without running crystal");
    a_bias_uniform: assert property (
        O_HALF_VDD_EN == 4'h0 || O_HALF_VDD_EN == 4'hf)
        else $error("bias pins disagree");
    a_bias_by_write: assert property (
        $changed(O_HALF_VDD_EN) |-> $past(O_WB_ACK) || $past(O_WB_ACK, 2))
        else $error("bias changed without a register write");
    a_wake_holds: assert property (
        I_WAKE_REQ && !O_WAKE_HOLD |=> O_WAKE_HOLD)
        else $error("wake request not taken");
    a_wake_min_len: assert property (
        $rose(O_WAKE_HOLD) |-> !O_WAKE_DONE [*8])
        else $error("wake finished far too early");
    a_done_pulse: assert property (O_WAKE_DONE |=> !O_WAKE_DONE)
        else $error("wake done longer than one cycle");
    a_done_ends_hold: assert property (
        O_WAKE_DONE |=> !O_WAKE_HOLD)
        else $error("wake hold stays after done");
    a_lvr_cause: assert property (
        $rose(O_LVR_RESET) |-> $past(I_LVR_LOW))
        else $error("low voltage reset without low supply");
    a_boot_covers: assert property (O_LVR_RESET |-> O_BOOT_HOLD)
        else $error("boot hold low during reset");
    a_wdt_quiet_off: assert property (
        !I_WDT_ENABLE && !$past(I_WDT_ENABLE) |-> !O_WDT_TIMEOUT)
        else $error("watchdog fired while disabled");
endmodule : wakeup_lvr_ctrl_monitor

bind wakeup_lvr_ctrl wakeup_lvr_ctrl_monitor wakeup_lvr_ctrl_monitor_i (
    .I_CLK(I_CLK),
    .I_RESET_N(I_RESET_N),
    .I_WB_CYC(I_WB_CYC),
    .I_WB_STB(I_WB_STB),
    .I_XTAL_RUNNING(I_XTAL_RUNNING),
    .I_WAKE_REQ(I_WAKE_REQ),
    .I_LVR_LOW(I_LVR_LOW),
    .I_WDT_ENABLE(I_WDT_ENABLE),
    .O_WB_ACK(O_WB_ACK),
    .O_WB_DAT(O_WB_DAT),
    .O_XTAL_LOW_DRIVE(O_XTAL_LOW_DRIVE),
    .O_HALF_VDD_EN(O_HALF_VDD_EN),
    .O_WAKE_HOLD(O_WAKE_HOLD),
    .O_WAKE_DONE(O_WAKE_DONE),
    .O_LVR_RESET(O_LVR_RESET),
    .O_BOOT_HOLD(O_BOOT_HOLD),
    .O_WDT_TIMEOUT(O_WDT_TIMEOUT)
);

`default_nettype wire

// [sim/wakeup_lvr_ctrl_tb.sv]
// self-checking bench for the option register and sequencing block
`timescale 1ns/1ns
`default_nettype none
`include "wakeup_lvr_params.svh"

`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin \
    num_errors++; $display("FAIL %0t got %0h exp %0h", $time, a, b); end end

module wakeup_lvr_ctrl_tb;
    localparam logic [7:0] OPT_ADR = {`OPT_REG_INDEX, 2'b00};
    localparam logic [7:0] STAT_ADR = {`STAT_REG_INDEX, 2'b00};
    localparam int PER [4] = '{2048, 4096, 16384, 256};
    localparam int WK [3] = '{132, 634, 2634};
    logic I_CLK = 1'b0;
    logic I_RESET_N = 1'b0;
    logic I_WB_CYC = 1'b0;
    logic I_WB_STB = 1'b0;
    logic I_WB_WE = 1'b0;
    logic [7:0] I_WB_ADR = 8'h00;
    logic [3:0] I_WB_SEL = 4'h0;
    logic [31:0] I_WB_DAT = 32'h0;
    logic I_LRC_TICK = 1'b0;
    logic I_WAKE_REQ = 1'b0;
    logic I_SUSPEND_SYS = 1'b0;
    logic I_HIGH_RC_USED = 1'b0;
    logic I_EXT_OSC_EN = 1'b0; // never with fast wake
    logic I_XTAL_RUNNING = 1'b0;
    logic I_LVR_LOW = 1'b0;
    logic I_WDT_ENABLE = 1'b0;
    logic I_WDT_KICK = 1'b0;
    logic O_WB_ACK;
    logic [31:0] O_WB_DAT;
    logic O_XTAL_LOW_DRIVE;
    logic [3:0] O_HALF_VDD_EN;
    logic O_WAKE_HOLD;
    logic O_WAKE_DONE;
    logic O_LVR_RESET;
    logic O_BOOT_HOLD;
    logic O_WDT_TIMEOUT;
    logic O_WDT_SYS_CLK;
    logic tick_on = 1'b0;
    int num_errors = 0;
    int total_checks = 0;

    wakeup_lvr_ctrl wakeup_lvr_ctrl_i (.*);

    initial begin
        forever #20 I_CLK = ~I_CLK;
    end

    // low rc tick every second cycle keeps long counts short
    always @(posedge I_CLK) begin
        I_LRC_TICK <= tick_on & ~I_LRC_TICK;
    end

    // ------
    // tasks
    // ------
    task automatic end_of_test;
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : end_of_test

    task automatic wb(input logic we, input logic [7:0] adr,
        input logic [7:0] wd, output logic [31:0] rd);
        int n;
        @(posedge I_CLK);
        I_WB_CYC <= 1'b1;
        I_WB_STB <= 1'b1;
        I_WB_WE <= we;
        I_WB_ADR <= adr;
        I_WB_SEL <= 4'h1;
        I_WB_DAT <= {24'h0, wd};
        n = 0;
        do begin
            @(posedge I_CLK);
            n++;
        end while (O_WB_ACK !== 1'b1 && n < 20);
        rd = O_WB_DAT;
        I_WB_CYC <= 1'b0;
        I_WB_STB <= 1'b0;
        I_WB_WE <= 1'b0;
        if (O_WB_ACK !== 1'b1) begin
            num_errors++;
            end_of_test();
        end
    endtask : wb

    task automatic wr(input logic [7:0] wd);
        logic [31:0] d;
        wb(1'b1, OPT_ADR, wd, d);
    endtask : wr

    // waits for an output event, counting cycles and low rc ticks
    task automatic meas(input int sel, output int cyc, output int tk);
        logic hit;
        cyc = 0;
        tk = 0;
        do begin
            @(posedge I_CLK);
            #1;
            cyc++;
            tk += (I_LRC_TICK === 1'b1);
            case (sel)
                0: hit = (O_WDT_TIMEOUT === 1'b1);
                1: hit = (O_WAKE_DONE === 1'b1);
                default: hit = (O_BOOT_HOLD === 1'b0);
            endcase
        end while (!hit && cyc < 40000);
        // return on an edge so the caller drives inputs there
        @(posedge I_CLK);
        if (!hit) begin
            num_errors++;
            end_of_test();
        end
    endtask : meas

    task automatic wake(output int c, output int t);
        @(posedge I_CLK);
        I_WAKE_REQ <= 1'b1;
        @(posedge I_CLK);
        I_WAKE_REQ <= 1'b0;
        meas(1, c, t);
    endtask : wake

    function automatic int near(input int n, input int e, input int t);
        return (n >= e - t && n <= e + t) ? e : n;
    endfunction : near

    // ------
    // sequence
    // ------
    initial begin
        int c;
        int t;
        logic [31:0] d;
        repeat (6) @(posedge I_CLK);
        I_RESET_N <= 1'b1;
        @(posedge I_CLK);
        #1;
        `CHK(O_HALF_VDD_EN, 4'h0)
        `CHK(O_WDT_SYS_CLK, 1'b0)
        wr(8'h50);
        repeat (2) @(posedge I_CLK);
        #1;
        `CHK(O_HALF_VDD_EN, 4'hf)
        `CHK(O_XTAL_LOW_DRIVE, 1'b0)
        @(posedge I_CLK);
        I_XTAL_RUNNING <= 1'b1;
        repeat (2) @(posedge I_CLK);
        #1;
        `CHK(O_XTAL_LOW_DRIVE, 1'b1)
        wb(1'b0, OPT_ADR, 8'h00, d);
        `CHK(d, 32'h0)
        wb(1'b0, 8'h00, 8'h00, d);
        `CHK(d, 32'h0)
        wr(8'h00);
        repeat (2) @(posedge I_CLK);
        #1;
        `CHK(O_HALF_VDD_EN, 4'h0)
        `CHK(O_XTAL_LOW_DRIVE, 1'b0)
        tick_on <= 1'b1;
        for (int s = 0; s < 4; s++) begin
            wr(8'(s));
            I_WDT_ENABLE <= 1'b1;
            meas(0, c, t);
            `CHK(near(t, PER[s], 2), PER[s])
            I_WDT_ENABLE <= 1'b0;
        end
        wr(8'h23); // watchdog is off before fast wake
        repeat (2) @(posedge I_CLK);
        #1;
        `CHK(O_WDT_SYS_CLK, 1'b1)
        @(posedge I_CLK);
        I_WDT_ENABLE <= 1'b1;
        meas(0, c, t);
        `CHK(near(c, 256, 2), 256)
        repeat (100) @(posedge I_CLK);
        I_WDT_KICK <= 1'b1;
        @(posedge I_CLK);
        I_WDT_KICK <= 1'b0;
        meas(0, c, t);
        `CHK(near(c, 256, 2), 256)
        I_WDT_ENABLE <= 1'b0;
        for (int m = 0; m < 3; m++) begin
            I_SUSPEND_SYS <= (m != 0);
            I_HIGH_RC_USED <= (m == 1);
            wake(c, t);
            `CHK(near(c, WK[m], 6), WK[m])
            `CHK(O_WAKE_HOLD, 1'b0)
        end
        wr(8'h00);
        wake(c, t);
        `CHK(near(t, 1024, 3), 1024)
        for (int f = 0; f < 2; f++) begin
            wr(f ? 8'h08 : 8'h00);
            I_LVR_LOW <= 1'b1;
            repeat (3) @(posedge I_CLK);
            #1;
            `CHK(O_LVR_RESET, 1'b1)
            `CHK(O_BOOT_HOLD, 1'b1)
            wb(1'b0, STAT_ADR, 8'h00, d);
            `CHK(d, 32'h00000006)
            I_LVR_LOW <= 1'b0;
            meas(2, c, t);
            `CHK(near(t, f ? 64 : 1024, 2), f ? 64 : 1024)
        end
        wr(8'h04);
        I_LVR_LOW <= 1'b1;
        repeat (3) @(posedge I_CLK);
        #1;
        `CHK(O_LVR_RESET, 1'b0)
        `CHK(O_BOOT_HOLD, 1'b0)
        @(posedge I_CLK);
        I_LVR_LOW <= 1'b0;
        end_of_test();
    end
endmodule : wakeup_lvr_ctrl_tb

`default_nettype wire
